// >>> design/dma_chan_map.svh
// Offsets, field positions and counts of the DMA channel block.
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH
`define DMA_OFS_COUNT 8'h00
`define DMA_OFS_CTRL 8'h04
`define DMA_OFS_DEST 8'h08
`define DMA_OFS_CFG 8'h0C
`define DMA_CNT_W 24
`define DMA_CTRL_OVR 23
`define DMA_CTRL_ENDPOL 22
`define DMA_CTRL_ACKCYC 17
`define DMA_CTRL_ACKPOL 16
`define DMA_CTRL_DMH 15
`define DMA_CTRL_DML 14
`define DMA_CFG_START 0
`define DMA_CFG_DONE 1
`define DMA_CFG_SIZE_LO 2
`define DMA_CFG_SINGLE 4
`define DMA_CFG_TODEV 5
`define DMA_CFG_PEND 6
`define DMA_LAST_COUNT 24'h00_0001
`define DMA_FIFO_DEPTH 8
`endif

// >>> design/dma_chan_pkg.sv
// Types shared by the DMA channel block.
package dma_chan_pkg;
  typedef enum logic [1:0] {
    UNIT_BYTE = 2'h0,
    UNIT_WORD = 2'h1,
    UNIT_LONG = 2'h2,
    UNIT_16B = 2'h3
  } unit_size_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h3,
    ST_SPARE = 2'h2
  } chan_state_t;
  typedef struct packed {
    logic overrun_sel;
    logic end_signal_polarity;
    logic acknowledge_cycle_select;
    logic acknowledge_polarity;
    logic dest_mode_high;
    logic dest_mode_low;
  } chan_ctrl_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } write_beat_t;
endpackage

// >>> design/dma_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module dma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid_i & rdy_r;
    pop = out_ready_i & (cnt_r != '0);
    wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Ready is registered so the source never sees a combinational path.
    rdy_nxt = (cnt_nxt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      if (push) begin
        mem_r[wp_r] <= in_data_i;
      end
    end
  end

  assign in_ready_o = rdy_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
endmodule // dma_fifo
`default_nettype wire

// >>> design/dma_dest_step.sv
// Next destination address from unit size and destination mode.
`timescale 1ns/100ps
`default_nettype none
module dma_dest_step
  import dma_chan_pkg::*;
(
  input wire logic [31:0] addr_i,
  input wire unit_size_t size_i,
  input wire logic [1:0] mode_i,
  input wire logic hold_i,
  output logic [31:0] addr_o
);
  logic [31:0] step;

  always_comb begin
    case (size_i)
      UNIT_BYTE: step = 32'h0000_0001;
      UNIT_WORD: step = 32'h0000_0002;
      UNIT_LONG: step = 32'h0000_0004;
      default: step = 32'h0000_0010;
    endcase
    addr_o = addr_i;
    if (!hold_i) begin
      case (mode_i)
        2'h1: addr_o = addr_i + step; // [RL11]
        2'h2: addr_o = addr_i - step; // [RL11]
        default: addr_o = addr_i;
      endcase
    end
  end
endmodule // dma_dest_step
`default_nettype wire

// >>> design/dma_chan.sv
// One DMA channel: transfer count, channel control and acknowledge logic.
//
// Contract
// RL1: Count one is one; zero means 16777216.
// RL2: Count register reads remaining transfers while busy.
// RL3: Top eight count bits read zero.
// RL4: One 16-byte unit decrements count once.
// RL5: Count has no reset, holds in standby.
// RL6: Bit 23 selects overrun 0 or 1.
// RL7: Bit 22 sets end output polarity, channel 0.
// RL8: Bit 17 puts acknowledge in read/write cycle.
// RL9: Single address mode always drives acknowledge.
// RL10: Bit 16 sets acknowledge polarity, channels 0-1.
// RL11: Destination steps up or down by unit size.
// RL12: Software avoids mode 11 and bad 16-byte modes.
// RL13: Single address to device ignores destination mode.
// RL14: Reserved control bits read zero.
// RL15: End output matches acknowledge on last transfer.
// RL16: Count decrements per unit; finishes at zero.
`include "dma_chan_map.svh"
`timescale 1ns/100ps
`default_nettype none
module dma_chan
  import dma_chan_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter int FIFO_DEPTH = `DMA_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic src_valid_i,
  input wire logic [31:0] src_data_i,
  output logic src_ready_o,
  input wire logic transfer_request_input_i,
  output logic request_acknowledge_output_o,
  output logic transfer_end_output_o,
  output logic wr_valid_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o
);
  localparam logic HAS_EXT = (CHANNEL < 2);
  localparam logic HAS_END = (CHANNEL == 0);

  // Bus group.
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic access, wr_en;
  // Engine group.
  chan_state_t state_r, state_nxt;
  chan_ctrl_t ctrl_r, ctrl_nxt;
  unit_size_t size_r, size_nxt;
  logic single_r, single_nxt, todev_r, todev_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, pend_r, pend_nxt;
  logic [`DMA_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] dst_r, dst_nxt, dst_step, data_r, data_nxt;
  logic ack_r, ack_nxt, transfer_end_output_r, transfer_end_output_nxt;
  logic wv_r, wv_nxt;
  logic [31:0] wa_r, wa_nxt, wd_r, wd_nxt;
  logic ack_active, go, finish, req_seen;
  logic fifo_valid, fifo_pop;
  logic [31:0] fifo_data;

  function automatic logic [31:0] ctrl_word(input chan_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000; // [RL14]
    w[`DMA_CTRL_OVR] = c.overrun_sel;
    w[`DMA_CTRL_ENDPOL] = c.end_signal_polarity;
    w[`DMA_CTRL_ACKCYC] = c.acknowledge_cycle_select;
    w[`DMA_CTRL_ACKPOL] = c.acknowledge_polarity;
    w[`DMA_CTRL_DMH] = c.dest_mode_high;
    w[`DMA_CTRL_DML] = c.dest_mode_low;
    return w;
  endfunction

  dma_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i(src_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  dma_dest_step u_step (
    .addr_i(dst_r),
    .size_i(size_r),
    .mode_i({ctrl_r.dest_mode_high, ctrl_r.dest_mode_low}),
    .hold_i(single_r & todev_r), // [RL13]
    .addr_o(dst_step)
  );

  // Bus slave: one wait cycle, then pready for one cycle.
  always_comb begin
    access = psel_i & penable_i & ~pready_r;
    wr_en = psel_i & penable_i & pready_r & pwrite_i;
    pready_nxt = access;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (access) begin
      case (paddr_i)
        `DMA_OFS_COUNT: prdata_nxt = {8'h00, cnt_r}; // [RL2] [RL3]
        `DMA_OFS_CTRL: prdata_nxt = ctrl_word(ctrl_r); // [RL14]
        `DMA_OFS_DEST: prdata_nxt = dst_r;
        `DMA_OFS_CFG: begin
          prdata_nxt[`DMA_CFG_START] = busy_r;
          prdata_nxt[`DMA_CFG_DONE] = done_r;
          prdata_nxt[`DMA_CFG_SIZE_LO +: 2] = size_r;
          prdata_nxt[`DMA_CFG_SINGLE] = single_r;
          prdata_nxt[`DMA_CFG_TODEV] = todev_r;
          prdata_nxt[`DMA_CFG_PEND] = pend_r;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // Transfer engine.
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    size_nxt = size_r;
    single_nxt = single_r;
    todev_nxt = todev_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    cnt_nxt = cnt_r;
    dst_nxt = dst_r;
    data_nxt = data_r;
    wv_nxt = 1'b0;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    req_seen = transfer_request_input_i | pend_r;
    go = busy_r & req_seen & fifo_valid & (state_r == ST_IDLE);
    fifo_pop = go;
    // Overrun 1 remembers one request raised while a transfer is under way.
    pend_nxt = pend_r;
    if (go) begin
      pend_nxt = 1'b0;
    end else if (ctrl_r.overrun_sel && transfer_request_input_i && state_r != ST_IDLE) begin
      pend_nxt = 1'b1; // [RL6]
    end
    finish = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_READ;
          data_nxt = fifo_data;
        end
      end
      ST_READ: begin
        if (single_r) begin
          state_nxt = ST_IDLE;
          finish = 1'b1;
          wv_nxt = 1'b1;
        end else begin
          state_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        state_nxt = ST_IDLE;
        finish = 1'b1;
        wv_nxt = 1'b1;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (wv_nxt) begin
      wa_nxt = dst_r;
      wd_nxt = data_r;
    end
    if (finish) begin
      // A 16-byte unit is one step here just like any other size.
      cnt_nxt = cnt_r - `DMA_LAST_COUNT; // [RL1] [RL4] [RL16]
      dst_nxt = dst_step; // [RL11]
      if (cnt_r == `DMA_LAST_COUNT) begin
        busy_nxt = 1'b0; // [RL16]
      end
    end
    // Software writes; hardware setting of done wins over its clear.
    if (wr_en) begin
      case (paddr_i)
        `DMA_OFS_COUNT: cnt_nxt = pwdata_i[`DMA_CNT_W-1:0]; // [RL3]
        `DMA_OFS_CTRL: begin
          ctrl_nxt.overrun_sel = HAS_EXT & pwdata_i[`DMA_CTRL_OVR]; // [RL6]
          ctrl_nxt.end_signal_polarity = HAS_END & pwdata_i[`DMA_CTRL_ENDPOL]; // [RL7]
          ctrl_nxt.acknowledge_cycle_select = HAS_EXT & pwdata_i[`DMA_CTRL_ACKCYC]; // [RL8]
          ctrl_nxt.acknowledge_polarity = HAS_EXT & pwdata_i[`DMA_CTRL_ACKPOL]; // [RL10]
          ctrl_nxt.dest_mode_high = pwdata_i[`DMA_CTRL_DMH];
          ctrl_nxt.dest_mode_low = pwdata_i[`DMA_CTRL_DML];
        end
        `DMA_OFS_DEST: dst_nxt = pwdata_i;
        `DMA_OFS_CFG: begin
          if (pwdata_i[`DMA_CFG_START]) begin
            busy_nxt = 1'b1;
          end
          if (pwdata_i[`DMA_CFG_DONE]) begin
            done_nxt = 1'b0;
          end
          size_nxt = unit_size_t'(pwdata_i[`DMA_CFG_SIZE_LO +: 2]);
          single_nxt = HAS_EXT & pwdata_i[`DMA_CFG_SINGLE];
          todev_nxt = pwdata_i[`DMA_CFG_TODEV];
        end
        default: ;
      endcase
    end
    if (finish && cnt_r == `DMA_LAST_COUNT) begin
      done_nxt = 1'b1;
    end
    // Acknowledge follows the cycle that will be on the bus next.
    if (single_r) begin
      ack_active = (state_nxt == ST_READ); // [RL9]
    end else if (ctrl_r.acknowledge_cycle_select) begin
      ack_active = (state_nxt == ST_WRITE); // [RL8]
    end else begin
      ack_active = (state_nxt == ST_READ); // [RL8]
    end
    ack_active = ack_active & HAS_EXT;
    ack_nxt = ack_active ~^ ctrl_r.acknowledge_polarity; // [RL10]
    transfer_end_output_nxt = (HAS_END & ack_active & (cnt_r == `DMA_LAST_COUNT))
      ~^ ctrl_r.end_signal_polarity; // [RL7] [RL15]
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      state_r <= ST_IDLE;
      ctrl_r <= '0;
      size_r <= UNIT_BYTE;
      single_r <= 1'b0;
      todev_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pend_r <= 1'b0;
      ack_r <= 1'b1;
      transfer_end_output_r <= 1'b1;
      wv_r <= 1'b0;
      wa_r <= 32'h0000_0000;
      wd_r <= 32'h0000_0000;
    end else if (ce_i) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      size_r <= size_nxt;
      single_r <= single_nxt;
      todev_r <= todev_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pend_r <= pend_nxt;
      ack_r <= ack_nxt;
      transfer_end_output_r <= transfer_end_output_nxt;
      wv_r <= wv_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
    end
  end

  // Count, destination address and data keep no reset so a reset or standby leaves them intact.
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      cnt_r <= cnt_nxt; // [RL5]
      dst_r <= dst_nxt;
      data_r <= data_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign request_acknowledge_output_o = ack_r;
  assign transfer_end_output_o = transfer_end_output_r;
  assign wr_valid_o = wv_r;
  assign wr_addr_o = wa_r;
  assign wr_data_o = wd_r;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_dual_read;
    ce_i && state_r == ST_READ && !single_r;
  endsequence
  sequence s_then_write;
    ce_i ##1 ce_i && state_r == ST_WRITE;
  endsequence

  a_count_top_zero: assert property ( // [RL3]
    pready_r && paddr_i == `DMA_OFS_COUNT |-> prdata_r[31:24] == 8'h00)
    else $error("count read shows nonzero top bits");
  a_ctrl_reserved: assert property ( // [RL14]
    pready_r |-> (paddr_i != `DMA_OFS_CTRL || (prdata_r & 32'hFF3C_3FFF) == 32'h0000_0000))
    else $error("control read shows reserved bits");
  a_count_step: assert property ( // [RL16]
    ce_i && finish && !wr_en |=> cnt_r == $past(cnt_r) - `DMA_LAST_COUNT)
    else $error("count did not fall by one per unit");
  a_dual_sequence: assert property ( // [RL8]
    s_dual_read |-> s_then_write or (##1 !ce_i))
    else $error("dual mode read not followed by write");
  a_ack_read_cycle: assert property ( // [RL8]
    ce_i && !single_r && HAS_EXT && state_nxt == ST_READ && !ctrl_r.acknowledge_cycle_select
    |=> request_acknowledge_output_o == ctrl_r.acknowledge_polarity)
    else $error("acknowledge missing in read cycle");
  a_ack_single: assert property ( // [RL9]
    ce_i && single_r && state_nxt == ST_READ
    |=> request_acknowledge_output_o == ctrl_r.acknowledge_polarity)
    else $error("acknowledge missing in single mode");
  a_end_last_only: assert property ( // [RL15]
    ce_i && (transfer_end_output_o == ctrl_r.end_signal_polarity) && $stable(ctrl_r)
    |-> request_acknowledge_output_o == ctrl_r.acknowledge_polarity)
    else $error("end output active without acknowledge");
  a_finish_done: assert property ( // [RL16]
    ce_i && finish && cnt_r == `DMA_LAST_COUNT |=> done_r && !busy_r)
    else $error("channel did not finish at zero count");
  a_dest_hold: assert property ( // [RL13]
    ce_i && finish && single_r && todev_r && !wr_en |=> dst_r == $past(dst_r))
    else $error("destination moved in single mode to device");
  a_bus_answer: assert property (
    ce_i && psel_i && penable_i && !pready_r |=> pready_r ##1 !pready_r || !ce_i)
    else $error("bus answer not one cycle");
  a_count_readback: assert property ( // [RL2]
    pready_r && !pwrite_i && paddr_i == `DMA_OFS_COUNT |-> prdata_r[23:0] == $past(cnt_r))
    else $error("count read does not show remaining transfers");
  a_overrun_hold: assert property ( // [RL6]
    ce_i && ctrl_r.overrun_sel && transfer_request_input_i && state_r == ST_READ |=> pend_r)
    else $error("overrun 1 did not remember a request");
  a_overrun_quiet: assert property ( // [RL6]
    ce_i && !ctrl_r.overrun_sel && !pend_r |=> !pend_r)
    else $error("overrun 0 remembered a request");
endmodule // dma_chan
`default_nettype wire

// >>> dv/ext_periph.sv
// Behavioural external peripheral that raises transfer requests.
`timescale 1ns/100ps
`default_nettype none
module ext_periph (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic slow_i,
  output logic req_o
);
  logic [1:0] ph_r;
  always_ff @(posedge clk_sys_i) begin
    ph_r <= rstn_i ? ph_r + 2'h1 : 2'h0;
  end
  // A slow peripheral requests one cycle in four, so no request lands mid-transfer.
  assign req_o = en_i & (~slow_i | (ph_r == 2'h0));
endmodule // ext_periph
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench of the DMA channel block.
`include "dma_chan_map.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, src_valid = 1'b0, en = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, src_data = 32'h0000_0000, exp_addr, stp;
  logic [31:0] prdata, wr_addr, wr_data;
  logic pready, pslverr, src_ready, req, ack, transfer_end_output, wr_valid, ack_pol, end_pol;
  logic [31:0] data_q[$];
  int num_errors = 0, n_compared = 0, n_ack, n_transfer_end_output, n_beat;

  always #20 clk_sys_i = ~clk_sys_i;

  dma_chan #(.CHANNEL(0)) i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .src_valid_i(src_valid),
    .src_data_i(src_data), .src_ready_o(src_ready), .transfer_request_input_i(req),
    .request_acknowledge_output_o(ack), .transfer_end_output_o(transfer_end_output),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  ext_periph i_periph (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .en_i(en), .slow_i(slow),
    .req_o(req));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) chk("pready", 32'h0000_0001, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never drops and raises psel in one time step.
    @(posedge clk_sys_i);
  endtask

  // Words are offered until taken; a word still refused after four edges ends the burst.
  task automatic push(input int n, output int acc);
    int k;
    logic [31:0] v;
    acc = 0;
    for (int i = 0; i < n; i++) begin
      v = $urandom;
      src_valid <= 1'b1;
      src_data <= v;
      k = 0;
      do begin
        @(posedge clk_sys_i);
        k++;
      end while (src_ready !== 1'b1 && k < 4);
      if (src_ready !== 1'b1) break;
      data_q.push_back(v);
      acc++;
    end
    src_valid <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  function automatic logic [31:0] step_of(logic [1:0] sz, logic [1:0] md, logic hold);
    logic [31:0] s;
    s = (sz == 2'h3) ? 32'h0000_0010 : (32'h0000_0001 << sz);
    if (hold || md == 2'h0) return 32'h0000_0000;
    return (md == 2'h1) ? s : -s;
  endfunction

  always @(posedge clk_sys_i) begin
    if (rstn_i) begin
      // Counted only while requests run, so the idle level flip of a polarity write is ignored.
      if (en && ack === ack_pol) n_ack++;
      if (en && transfer_end_output === end_pol) begin
        n_transfer_end_output++;
        chk("transfer_end_output_with_ack", {31'h0, ack_pol}, {31'h0, ack});
      end
      if (wr_valid === 1'b1) begin
        chk("wr_addr", exp_addr, wr_addr);
        chk("wr_data", data_q.pop_front(), wr_data);
        exp_addr = exp_addr + stp;
        n_beat++;
      end
    end
  end

  task automatic run(input int t);
    logic [31:0] r, d;
    logic e, sgl, dev;
    logic [1:0] sz, md;
    int n, acc;
    sz = (t == 1) ? 2'h2 : (t == 0) ? 2'h3 : 2'($urandom_range(3, 0));
    md = (t == 1) ? 2'h2 : 2'h1;
    sgl = (t >= 2);
    dev = (t == 3);
    ack_pol = (t == 1);
    end_pol = (t == 1);
    data_q.delete();
    push((t == 0) ? 9 : $urandom_range(5, 1), acc);
    if (t == 0) chk("fifo_fill", 32'h0000_0008, acc);
    d = $urandom & 32'hFFFF_FFF0;
    exp_addr = d;
    stp = step_of(sz, md, dev);
    n_ack = 0;
    n_transfer_end_output = 0;
    n_beat = 0;
    apb(1'b1, `DMA_OFS_CTRL, {8'h00, t == 2, end_pol, 4'h0, t == 1, ack_pol, md, 14'h0000}, r, e);
    apb(1'b1, `DMA_OFS_COUNT, acc, r, e);
    apb(1'b1, `DMA_OFS_DEST, d, r, e);
    apb(1'b1, `DMA_OFS_CFG, {26'h0, dev, sgl, sz, 2'b11}, r, e);
    en <= 1'b1;
    slow <= (t == 3);
    n = 0;
    do begin
      apb(1'b0, `DMA_OFS_CFG, 32'h0000_0000, r, e);
      n++;
    end while (r[`DMA_CFG_START] !== 1'b0 && n < 300);
    en <= 1'b0;
    chk("done_flag", 32'h0000_0001, {31'h0, r[`DMA_CFG_DONE]});
    chk("pend_flag", {31'h0, t == 2}, {31'h0, r[`DMA_CFG_PEND]});
    apb(1'b0, `DMA_OFS_COUNT, 32'h0000_0000, r, e);
    chk("count_left", 32'h0000_0000, r);
    chk("ack_units", acc, n_ack);
    chk("transfer_end_output_units", 32'h0000_0001, n_transfer_end_output);
    chk("beats", acc, n_beat);
    $display("test %0d done, %0d units", t, acc);
  endtask

  initial begin
    logic [31:0] r, d;
    logic e;
    void'($urandom(32'h4b49_8131));
    ack_pol = 1'b0;
    end_pol = 1'b0;
    stp = 32'h0000_0000;
    exp_addr = 32'h0000_0000;
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, `DMA_OFS_CTRL, 32'h0000_0000, r, e);
    chk("ctrl_reset", 32'h0000_0000, r);
    apb(1'b1, `DMA_OFS_CTRL, 32'h00C3_4000, r, e);
    apb(1'b0, `DMA_OFS_CTRL, 32'h0000_0000, r, e);
    chk("ctrl_bits", 32'h00C3_4000, r);
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    chk("unmapped_data", 32'h0000_0000, r);
    $display("test register access done");
    d = $urandom & 32'h00FF_FFFF;
    apb(1'b1, `DMA_OFS_COUNT, d, r, e);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, `DMA_OFS_COUNT, 32'h0000_0000, r, e);
    chk("count_kept", d, r);
    apb(1'b0, `DMA_OFS_CTRL, 32'h0000_0000, r, e);
    chk("ctrl_after_reset", 32'h0000_0000, r);
    $display("test reset keeps count done");
    for (int t = 0; t < 4; t++) run(t);
    conclude();
  end

  // The four transfers need a few hundred cycles; this span leaves a wide margin.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    num_errors++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
